// ### src/spmb_top.sv
// Slave port mailbox: three outbound and three inbound byte registers
// between an external master (select lines, strobes) and local software (APB).
// Assumes the master pins are synchronous to i_clk and strobes last >= 2 cycles.
//
// How it works
// RULE1: Data pins shared with parallel port A
// RULE2: Two select lines pick one outbound register
// RULE3: Read strobe drives selected outbound byte out
// RULE4: Software writes outbound registers over the bus
// RULE5: Three inbound registers carry master data in
// RULE6: Write strobe captures byte into selected register
// RULE7: Software reads inbound registers over the bus
// RULE8: Status bit marks which inbound register written
// RULE9: Enabled interrupt fires on inbound write
// RULE10: Outbound write raises attention line to master
// RULE11: Line shows slave read all inbound data
// RULE12: Line shows unread outbound data pending
// RULE13: Reads clear pending and written flags
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none

module spmb_top
	import spmb_pkg::*;
(
	// Clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	// APB slave
	input  wire logic             i_psel,
	input  wire logic             i_penable,
	input  wire logic             i_pwrite,
	input  wire logic [SPMB_AW-1:0] i_paddr,
	input  wire logic [31:0]      i_pwdata,
	output logic [31:0]           o_prdata,
	output logic                  o_pready,
	output logic                  o_pslverr,
	// Master side strobes and selects
	input  wire logic [1:0]       i_sp_sel,
	input  wire logic             i_sp_rd_n,
	input  wire logic             i_sp_wr_n,
	output logic                  o_sp_wr_ready,
	output logic                  o_sp_attn,
	output logic                  o_sp_read_all,
	output logic                  o_sp_out_pend,
	// Shared port A pins
	input  wire logic [7:0]       i_pa_data,
	output logic [7:0]            o_pa_data,
	output logic [7:0]            o_pa_oe,
	// Interrupt to local processor
	output logic                  o_slave_irq
);

	// ==========================================================
	// Select decode, shared by capture and read-clear paths
	function automatic logic [2:0] sel_hot(input logic [1:0] sel);
		logic [2:0] h;
		h = 3'h0;
		if (sel < 2'(SPMB_NREG)) begin
			h[sel] = 1'b1;
		end
		return h;
	endfunction : sel_hot

	// ==========================================================
	// State
	logic [7:0]  out_q [SPMB_NREG];
	logic [7:0]  out_d [SPMB_NREG];
	logic [7:0]  in_q  [SPMB_NREG];
	logic [7:0]  in_d  [SPMB_NREG];
	logic [2:0]  out_pend_q, out_pend_d, in_new_q, in_new_d;
	logic [1:0]  ctrl_q, ctrl_d;
	logic [7:0]  pa_out_q, pa_out_d, pa_dir_q, pa_dir_d;
	logic        attn_q, attn_d;
	logic [31:0] prdata_q, prdata_d;
	logic        pready_q, pready_d, pslverr_q, pslverr_d;
	logic        rd_n_q, wr_n_q;
	logic [7:0]  pa_data_q, pa_data_d, pa_oe_q, pa_oe_d;
	logic        irq_q, all_q, wr_ready_q;
	logic        pend_any_q;                          // Pending line, kept in its own flop

	// ==========================================================
	// Bus decode
	logic        acc_first, acc_done, wr_done, rd_done;
	logic [2:0]  out_wr, in_rd_clr, in_addr_hit;
	logic        sp_en, rd_end, wr_start;
	logic [2:0]  rd_clr, drain_hot;
	spmb_wr_type push_data, drain_data;
	logic        push_ready, drain_valid, drain_ready;
	logic [7:0]  rd_sel_data;

	assign acc_first = i_psel & i_penable & ~pready_q;
	assign acc_done  = i_psel & i_penable & pready_q;
	assign wr_done   = acc_done & i_pwrite;
	assign rd_done   = acc_done & ~i_pwrite;
	assign sp_en     = ctrl_q[SPMB_CTRL_SPEN];

	// Per-register write strobes and read clears
	generate
		for (genvar i = 0; i < SPMB_NREG; i++) begin : g_hit
			assign out_wr[i]      = wr_done & (i_paddr == SPMB_OFF_OUT[i]); // see RULE4
			assign in_addr_hit[i] = (i_paddr == SPMB_OFF_IN[i]);
			assign in_rd_clr[i]   = rd_done & in_addr_hit[i];              // see RULE13
		end
	endgenerate

	// APB read mux, write effects at the edge pready is seen
	always_comb begin
		prdata_d  = prdata_q;
		pslverr_d = pslverr_q;
		pready_d  = acc_first;
		ctrl_d    = ctrl_q;
		pa_out_d  = pa_out_q;
		pa_dir_d  = pa_dir_q;
		out_d     = out_q;
		if (acc_first) begin
			pslverr_d = 1'b0;
			prdata_d  = SPMB_WORD_RST;
			if (i_paddr == SPMB_OFF_OUT[0]) begin
				prdata_d[7:0] = out_q[0];
			end else if (i_paddr == SPMB_OFF_OUT[1]) begin
				prdata_d[7:0] = out_q[1];
			end else if (i_paddr == SPMB_OFF_OUT[2]) begin
				prdata_d[7:0] = out_q[2];
			end else if (in_addr_hit[0]) begin
				prdata_d[7:0] = in_q[0];                   // see RULE7
			end else if (in_addr_hit[1]) begin
				prdata_d[7:0] = in_q[1];                   // see RULE7
			end else if (in_addr_hit[2]) begin
				prdata_d[7:0] = in_q[2];                   // see RULE7
			end else if (i_paddr == SPMB_OFF_STAT) begin
				prdata_d[SPMB_ST_IN_LSB +: 3]  = in_new_q;  // see RULE8
				prdata_d[SPMB_ST_OUT_LSB +: 3] = out_pend_q;
				prdata_d[SPMB_ST_ATTN]         = attn_q;
				prdata_d[SPMB_ST_BUF]          = drain_valid;
			end else if (i_paddr == SPMB_OFF_CTRL) begin
				prdata_d[1:0] = ctrl_q;
			end else if (i_paddr == SPMB_OFF_PA_OUT) begin
				prdata_d[7:0] = pa_out_q;
			end else if (i_paddr == SPMB_OFF_PA_DIR) begin
				prdata_d[7:0] = pa_dir_q;
			end else if (i_paddr == SPMB_OFF_PA_IN) begin
				prdata_d[7:0] = i_pa_data;
			end else begin
				pslverr_d = 1'b1;                          // Unmapped: error, zero data
			end
		end
		if (wr_done) begin
			for (int i = 0; i < SPMB_NREG; i++) begin
				if (out_wr[i]) begin
					out_d[i] = i_pwdata[7:0];              // see RULE4
				end
			end
			if (i_paddr == SPMB_OFF_CTRL) begin
				ctrl_d = i_pwdata[1:0];
			end else if (i_paddr == SPMB_OFF_PA_OUT) begin
				pa_out_d = i_pwdata[7:0];
			end else if (i_paddr == SPMB_OFF_PA_DIR) begin
				pa_dir_d = i_pwdata[7:0];
			end
		end
	end

	// ==========================================================
	// Master strobes; inputs are synchronous, so one flop finds edges
	assign rd_end      = ~rd_n_q & i_sp_rd_n & sp_en;
	assign wr_start    = wr_n_q & ~i_sp_wr_n & sp_en;   // see RULE6
	assign rd_clr      = rd_end ? sel_hot(i_sp_sel) : 3'h0; // see RULE13
	assign push_data   = '{sel: i_sp_sel, data: i_pa_data};
	assign rd_sel_data = (i_sp_sel < 2'(SPMB_NREG)) ? out_q[i_sp_sel] : SPMB_BYTE_RST;
	// Hold the drain while software reads an inbound register, so a
	// read never sees a byte that changes under it mid-transfer
	assign drain_ready = ~(i_psel & ~i_pwrite & |in_addr_hit);
	assign drain_hot   = (drain_valid & drain_ready) ? sel_hot(drain_data.sel) : 3'h0;

	spmb_buf u_buf (
		.i_clk       (i_clk),
		.i_rst       (i_rst),
		.i_in_valid  (wr_start),
		.i_in_data   (push_data),
		.o_in_ready  (push_ready),
		.o_out_valid (drain_valid),
		.o_out_data  (drain_data),
		.i_out_ready (drain_ready)
	);

	// Flags: a new event wins over a clear in the same cycle
	generate
		for (genvar i = 0; i < SPMB_NREG; i++) begin : g_flag
			assign out_pend_d[i] = out_wr[i] | (out_pend_q[i] & ~rd_clr[i]);      // see RULE12
			assign in_new_d[i]   = drain_hot[i] | (in_new_q[i] & ~in_rd_clr[i]);  // see RULE8
			assign in_d[i]       = drain_hot[i] ? drain_data.data : in_q[i];      // see RULE5
		end
	endgenerate

	// Pin drive, attention and status lines
	always_comb begin
		attn_d = (|out_wr) | (attn_q & ~(wr_done & (i_paddr == SPMB_OFF_STAT)
			& i_pwdata[SPMB_ST_ATTN]));                     // see RULE10
		if (sp_en) begin
			// Selected outbound byte while the read strobe is low
			pa_data_d = rd_sel_data;                     // see RULE2
			pa_oe_d   = (~i_sp_rd_n && i_sp_sel < 2'(SPMB_NREG))
				? SPMB_BYTE_ONES : SPMB_BYTE_RST;         // see RULE3
		end else begin
			pa_data_d = pa_out_q;                        // see RULE1
			pa_oe_d   = pa_dir_q;
		end
	end

	// ==========================================================
	// Registers, plus the interrupt, read-all and pending-line terms formed here
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			for (int i = 0; i < SPMB_NREG; i++) begin
				out_q[i] <= SPMB_BYTE_RST;
				in_q[i]  <= SPMB_BYTE_RST;
			end
			out_pend_q <= SPMB_FLAG_RST;
			in_new_q   <= SPMB_FLAG_RST;
			ctrl_q     <= SPMB_CTRL_RST;
			pa_out_q   <= SPMB_BYTE_RST;
			pa_dir_q   <= SPMB_BYTE_RST;
			attn_q     <= 1'b0;
			prdata_q   <= SPMB_WORD_RST;
			pready_q   <= 1'b0;
			pslverr_q  <= 1'b0;
			rd_n_q     <= 1'b1;
			wr_n_q     <= 1'b1;
			pa_data_q  <= SPMB_BYTE_RST;
			pa_oe_q    <= SPMB_BYTE_RST;
			irq_q      <= 1'b0;
			all_q      <= 1'b1;
			wr_ready_q <= 1'b1;
			pend_any_q <= 1'b0;
		end else begin
			out_q      <= out_d;
			in_q       <= in_d;
			out_pend_q <= out_pend_d;
			in_new_q   <= in_new_d;
			ctrl_q     <= ctrl_d;
			pa_out_q   <= pa_out_d;
			pa_dir_q   <= pa_dir_d;
			attn_q     <= attn_d;
			prdata_q   <= prdata_d;
			pready_q   <= pready_d;
			pslverr_q  <= pslverr_d;
			rd_n_q     <= i_sp_rd_n;
			wr_n_q     <= i_sp_wr_n;
			pa_data_q  <= pa_data_d;
			pa_oe_q    <= pa_oe_d;
			irq_q      <= ctrl_q[SPMB_CTRL_IRQEN] & (|in_new_q); // see RULE9
			all_q      <= ~(|in_new_q) & ~drain_valid;           // see RULE11
			wr_ready_q <= push_ready;
			pend_any_q <= |out_pend_d;                          // see RULE12
		end
	end

	// Outputs straight from flops
	assign o_prdata      = prdata_q;
	assign o_pready      = pready_q;
	assign o_pslverr     = pslverr_q;
	assign o_pa_data     = pa_data_q;
	assign o_pa_oe       = pa_oe_q;
	assign o_sp_attn     = attn_q;
	assign o_sp_out_pend = pend_any_q;
	assign o_sp_read_all = all_q;
	assign o_sp_wr_ready = wr_ready_q;
	assign o_slave_irq   = irq_q;

	// ==========================================================
	// Checks
	a_apb_ready_one : assert property (@(posedge i_clk) disable iff (i_rst) // see RULE4
		(i_psel && i_penable && !o_pready) |=> o_pready ##1 !o_pready)
		else $error("pready not one cycle after access");

	a_pend_set_out : assert property (@(posedge i_clk) disable iff (i_rst) // see RULE12
		out_wr[0] |=> (out_pend_q[0] && o_sp_out_pend) [*1])
		else $error("outbound write did not mark pending");

	a_pend_clr_read : assert property (@(posedge i_clk) disable iff (i_rst) // see RULE13
		(rd_end && i_sp_sel == 2'h1 && !out_wr[1]) |=> !out_pend_q[1])
		else $error("master read did not clear pending");

	a_read_drive_oe : assert property (@(posedge i_clk) disable iff (i_rst) // see RULE3
		(sp_en && !i_sp_rd_n && i_sp_sel == 2'h2) |=>
		(o_pa_oe == SPMB_BYTE_ONES && o_pa_data == $past(rd_sel_data)))
		else $error("selected outbound byte not driven");

	a_port_a_share : assert property (@(posedge i_clk) disable iff (i_rst) // see RULE1
		!sp_en |=> (o_pa_oe == $past(pa_dir_q) && o_pa_data == $past(pa_out_q)))
		else $error("port A not driven from its own registers");

	a_in_capture_byte : assert property (@(posedge i_clk) disable iff (i_rst) // see RULE6
		(wr_start && push_ready && i_sp_sel == 2'h0 && !drain_valid) ##1 drain_ready
		|-> drain_valid ##1 (in_q[0] == $past(i_pa_data, 2) && in_new_q[0]))
		else $error("master write byte not captured");

	a_in_new_flag : assert property (@(posedge i_clk) disable iff (i_rst) // see RULE8
		drain_hot[2] |=> in_new_q[2] ##1 (in_new_q[2] || $past(in_rd_clr[2])))
		else $error("inbound written flag wrong");

	a_irq_follows : assert property (@(posedge i_clk) disable iff (i_rst) // see RULE9
		(|in_new_q && ctrl_q[SPMB_CTRL_IRQEN]) |=> o_slave_irq)
		else $error("slave interrupt missing");

	a_attn_on_write : assert property (@(posedge i_clk) disable iff (i_rst) // see RULE10
		(|out_wr) |=> o_sp_attn)
		else $error("attention not raised");

	a_read_all_line : assert property (@(posedge i_clk) disable iff (i_rst) // see RULE11
		(|in_new_q) |=> !o_sp_read_all)
		else $error("read-all asserted with unread data");

endmodule : spmb_top

`default_nettype wire

// ### src/spmb_pkg.sv
// Shared constants and types for the slave port mailbox.
// Assumes an APB master with 32-bit data and byte addressing.
package spmb_pkg;

	// ==========================================================
	// Register map (byte addresses, one aligned word each)
	localparam int          SPMB_NREG                = 3;
	localparam int          SPMB_AW                  = 8;
	localparam logic [7:0]  SPMB_OFF_OUT [SPMB_NREG] = '{8'h00, 8'h04, 8'h08};
	localparam logic [7:0]  SPMB_OFF_IN  [SPMB_NREG] = '{8'h0c, 8'h10, 8'h14};
	localparam logic [7:0]  SPMB_OFF_STAT            = 8'h18;
	localparam logic [7:0]  SPMB_OFF_CTRL            = 8'h1c;
	localparam logic [7:0]  SPMB_OFF_PA_OUT          = 8'h20;
	localparam logic [7:0]  SPMB_OFF_PA_DIR          = 8'h24;
	localparam logic [7:0]  SPMB_OFF_PA_IN           = 8'h28;

	// ==========================================================
	// Field positions
	localparam int          SPMB_ST_IN_LSB           = 0;
	localparam int          SPMB_ST_OUT_LSB          = 3;
	localparam int          SPMB_ST_ATTN             = 6;
	localparam int          SPMB_ST_BUF              = 7;
	localparam int          SPMB_CTRL_SPEN           = 0;
	localparam int          SPMB_CTRL_IRQEN          = 1;

	// ==========================================================
	// Reset values and widths
	localparam logic [7:0]  SPMB_BYTE_RST            = 8'h00;
	localparam logic [7:0]  SPMB_BYTE_ONES           = 8'hff;
	localparam logic [31:0] SPMB_WORD_RST            = 32'h0000_0000;
	localparam logic [1:0]  SPMB_CTRL_RST            = 2'h0;
	localparam logic [2:0]  SPMB_FLAG_RST            = 3'h0;
	localparam int          SPMB_BUF_DEPTH           = 2;

	// ==========================================================
	// One master write: selected register and data byte
	typedef struct packed {
		logic [1:0] sel;
		logic [7:0] data;
	} spmb_wr_type;

endpackage : spmb_pkg

// ### src/spmb_buf.sv
// Two-entry buffer for master writes heading to the inbound registers.
// Assumes the filler honours o_in_ready; the drain side may stall freely.
`timescale 1ns/1ps
`default_nettype none

module spmb_buf
	import spmb_pkg::*;
(
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// Filling side
	input  wire logic        i_in_valid,
	input  wire spmb_wr_type i_in_data,
	output logic             o_in_ready,
	// Draining side
	output logic             o_out_valid,
	output spmb_wr_type      o_out_data,
	input  wire logic        i_out_ready
);

	// ==========================================================
	// Storage and pointers
	spmb_wr_type mem_q [SPMB_BUF_DEPTH];
	spmb_wr_type mem_d [SPMB_BUF_DEPTH];
	logic        wptr_q, wptr_d, rptr_q, rptr_d;
	logic [1:0]  cnt_q, cnt_d;
	logic        push, pop;

	assign o_in_ready  = (cnt_q != 2'(SPMB_BUF_DEPTH));
	assign o_out_valid = (cnt_q != 2'h0);
	assign o_out_data  = mem_q[rptr_q];
	assign push        = i_in_valid & o_in_ready;
	assign pop         = o_out_valid & i_out_ready;

	// Next pointers, count and contents
	always_comb begin
		mem_d  = mem_q;
		wptr_d = wptr_q;
		rptr_d = rptr_q;
		cnt_d  = cnt_q;
		if (push) begin
			mem_d[wptr_q] = i_in_data;
			wptr_d        = ~wptr_q;
		end
		if (pop) begin
			rptr_d = ~rptr_q;
		end
		cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
	end

	// Register only
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			mem_q[0] <= '0;
			mem_q[1] <= '0;
			wptr_q   <= 1'b0;
			rptr_q   <= 1'b0;
			cnt_q    <= 2'h0;
		end else begin
			mem_q  <= mem_d;
			wptr_q <= wptr_d;
			rptr_q <= rptr_d;
			cnt_q  <= cnt_d;
		end
	end

	a_buf_no_over : assert property (@(posedge i_clk) disable iff (i_rst)
		(cnt_q == 2'h2) |-> !o_in_ready)
		else $error("buffer claims room while full");

endmodule : spmb_buf

`default_nettype wire

// ### tb/spmb_master_model.sv
// Behavioural external master for the slave port mailbox.
// Assumes pins are sampled on the rising edge of i_clk.
`timescale 1ns/1ps
`default_nettype none

module spmb_master_model (
	// Clock and port status
	input  wire logic       i_clk,
	input  wire logic       i_wr_ready,
	input  wire logic [7:0] i_pa_data,
	input  wire logic [7:0] i_pa_oe,
	// Selects, strobes and data
	output logic [1:0]      o_sel,
	output logic            o_rd_n,
	output logic            o_wr_n,
	output logic [7:0]      o_pa_data
);
	// =========================================================
	// Idle: strobes high before reset is released
	initial begin
		o_sel     = 2'h3;
		o_rd_n    = 1'b1;
		o_wr_n    = 1'b1;
		o_pa_data = 8'h00;
	end

	// =========================================================
	// Read: sel is held past the rising strobe, which clears pending
	task automatic mread(input logic [1:0] s, output logic [7:0] d, output logic [7:0] oe);
		@(posedge i_clk);
		o_sel  <= s;
		o_rd_n <= 1'b0;
		repeat (2) @(posedge i_clk);
		d  = i_pa_data; // Taken at the edge, values launched one edge earlier
		oe = i_pa_oe;
		@(posedge i_clk);
		o_rd_n <= 1'b1;
		repeat (3) @(posedge i_clk);
	endtask : mread

	// =========================================================
	// Write: never start a strobe into a full buffer
	task automatic mwrite(input logic [1:0] s, input logic [7:0] d);
		@(posedge i_clk);
		while (i_wr_ready !== 1'b1) @(posedge i_clk);
		o_sel     <= s;
		o_pa_data <= d;
		o_wr_n    <= 1'b0;
		repeat (2) @(posedge i_clk);
		o_wr_n    <= 1'b1;
		o_pa_data <= ~d; // Released lines do not keep the old byte
		repeat (2) @(posedge i_clk);
	endtask : mwrite
endmodule : spmb_master_model
`default_nettype wire

// ### tb/test_slave_port_mailbox.sv
// Self-checking bench for the slave port mailbox.
// Assumes spmb_pkg, spmb_top, spmb_buf and the master model are compiled first.
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_mismatch++; $display("Error at %0t ns: got %h expected %h", $time, got, exp); end end

module test_slave_port_mailbox
	import spmb_pkg::*;
;
	logic        clk, rst, psel, penable, pwrite, pready, pslverr, e;
	logic        wr_ready, attn, read_all, out_pend, irq, rd_n, wr_n;
	logic [7:0]  paddr, pa_out, pa_oe, m_pa, pa_wire, d, oe;
	logic [31:0] pwdata, prdata, r;
	logic [1:0]  sel;
	int          n_mismatch, num_checks, cyc;

	// Wire level: each bit is driven by whoever has it enabled
	assign pa_wire = (pa_oe & pa_out) | (~pa_oe & m_pa);

	spmb_top u_spmb_top (.i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_sp_sel(sel), .i_sp_rd_n(rd_n),
		.i_sp_wr_n(wr_n), .o_sp_wr_ready(wr_ready), .o_sp_attn(attn),
		.o_sp_read_all(read_all), .o_sp_out_pend(out_pend), .i_pa_data(pa_wire),
		.o_pa_data(pa_out), .o_pa_oe(pa_oe), .o_slave_irq(irq));

	spmb_master_model u_spmb_master_model (.i_clk(clk), .i_wr_ready(wr_ready),
		.i_pa_data(pa_wire), .i_pa_oe(pa_oe), .o_sel(sel), .o_rd_n(rd_n),
		.o_wr_n(wr_n), .o_pa_data(m_pa));

	// =========================================================
	// Clock and hang guard
	initial clk = 1'b0;
	always #2 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			n_mismatch++;
			end_sim();
		end
	end

	// =========================================================
	// APB transfer; answer taken and request released at the edge pready is seen
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// =========================================================
	// Scenarios
	task automatic t_reset;
		@(negedge clk);
		`CHK({read_all, wr_ready}, 2'h3)
		`CHK({attn, out_pend, irq}, 3'h0)
		`CHK(pa_oe, 8'h00)
		apb(1'b0, SPMB_OFF_STAT, 32'h0);
		`CHK(r, SPMB_WORD_RST)
	endtask : t_reset

	task automatic t_outbound;
		apb(1'b1, SPMB_OFF_CTRL, 32'h3);
		for (int i = 0; i < 3; i++) apb(1'b1, SPMB_OFF_OUT[i], 32'ha0 + 32'(i));
		@(negedge clk);
		`CHK({attn, out_pend}, 2'h3)
		apb(1'b0, SPMB_OFF_STAT, 32'h0);
		`CHK(r, 32'h78)
		apb(1'b1, SPMB_OFF_STAT, 32'h40);
		@(negedge clk);
		`CHK(attn, 1'b0)
		for (int i = 0; i < 3; i++) begin
			u_spmb_master_model.mread(2'(i), d, oe);
			`CHK(d, 8'ha0 + 8'(i))
			`CHK(oe, 8'hff)
			`CHK(out_pend, 1'(i < 2))
		end
		u_spmb_master_model.mread(2'h3, d, oe);
		`CHK(oe, 8'h00)
		apb(1'b0, SPMB_OFF_STAT, 32'h0);
		`CHK(r, 32'h0)
	endtask : t_outbound

	task automatic t_inbound;
		for (int i = 0; i < 3; i++) begin
			u_spmb_master_model.mwrite(2'(i), 8'h50 + 8'(i));
			@(negedge clk);
			`CHK({read_all, irq}, 2'h1)
		end
		apb(1'b0, SPMB_OFF_STAT, 32'h0);
		`CHK(r, 32'h7)
		for (int i = 0; i < 3; i++) begin
			apb(1'b0, SPMB_OFF_IN[i], 32'h0);
			`CHK(r, 32'h50 + 32'(i))
			apb(1'b0, SPMB_OFF_STAT, 32'h0);
			`CHK(r, (32'h6 << i) & 32'h7)
		end
		repeat (2) @(negedge clk);
		`CHK({read_all, irq}, 2'h2)
	endtask : t_inbound

	task automatic t_refuse;
		apb(1'b1, SPMB_OFF_IN[0], 32'hee);
		apb(1'b0, SPMB_OFF_IN[0], 32'h0);
		`CHK({e, r}, 33'h50)
		apb(1'b0, 8'h30, 32'h0);
		`CHK({e, r}, 33'h1_0000_0000)
		u_spmb_master_model.mwrite(2'h3, 8'h77);
		apb(1'b0, SPMB_OFF_STAT, 32'h0);
		`CHK(r, 32'h0)
		// Interrupt masked: flag set but no request
		apb(1'b1, SPMB_OFF_CTRL, 32'h1);
		u_spmb_master_model.mwrite(2'h1, 8'h61);
		@(negedge clk);
		`CHK(irq, 1'b0)
		apb(1'b0, SPMB_OFF_IN[1], 32'h0);
		`CHK(r, 32'h61)
	endtask : t_refuse

	task automatic t_porta;
		apb(1'b1, SPMB_OFF_CTRL, 32'h0);
		apb(1'b1, SPMB_OFF_PA_OUT, 32'h5a);
		apb(1'b1, SPMB_OFF_PA_DIR, 32'h0f);
		repeat (2) @(negedge clk);
		`CHK({pa_oe, pa_out[3:0]}, 12'h0fa)
		// Upper nibble from the master's released lines (inverse of 0x61)
		apb(1'b0, SPMB_OFF_PA_IN, 32'h0);
		`CHK(r, 32'h9a)
	endtask : t_porta

	// =========================================================
	// Verdict and main sequence
	task automatic end_sim;
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : end_sim

	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		rst = 1'b1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_outbound();
		t_inbound();
		t_refuse();
		t_porta();
		end_sim();
	end
endmodule : test_slave_port_mailbox
`default_nettype wire
